/* File: logic/glk_guard_lock_ctrl.sv */
// guard-lock controller: lock drive, safety output pair, diagnostics, apb registers
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module glk_guard_lock_ctrl #(
	parameter int TEST_PERIOD_CYC = glk_pkg::TEST_PERIOD_CYC,
	parameter int TEST_PULSE_CYC = glk_pkg::TEST_PULSE_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire glk_pkg::glk_cfg_s cfg_i,
	input wire logic lock_ctrl_i,
	input wire logic supply_ok_i,
	input wire logic manual_release_i,
	input wire logic actuator_present_i,
	input wire logic actuator_suitable_i,
	input wire logic [glk_pkg::CODE_W-1:0] actuator_code_i,
	input wire logic control_input_a_i,
	input wire logic control_input_b_i,
	input wire logic [1:0] channel_fb_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [glk_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [glk_pkg::DATA_W-1:0] pwdata_i,
	output logic [glk_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic [1:0] safety_output_channel_o,
	output logic lock_engaged_o,
	output logic diag_o,
	output logic irq_o
);
	glk_pkg::glk_lock_e lock_st;
	glk_pkg::glk_out_e out_st;
	glk_pkg::glk_out_e next_out_st;
	logic code_ok;
	logic taught;
	logic teach_done;
	logic [glk_pkg::CODE_W-1:0] stored_code;
	logic [1:0] test_off;
	logic test_fault;
	logic teach_req;
	logic fault_clr;
	logic engage_req;
	logic release_req;
	logic manual_flag;
	logic manual_now;
	logic cond;
	logic cond_q;
	logic present_q;
	logic [glk_pkg::IRQ_W-1:0] irq_stat;
	logic [glk_pkg::IRQ_W-1:0] irq_mask;
	logic [glk_pkg::IRQ_W-1:0] events;
	logic [glk_pkg::IRQ_W-1:0] irq_clr;
	logic [glk_pkg::DATA_W-1:0] status_word;
	logic release_var;
	logic apb_access;
	logic apb_wr;

	function automatic logic reg_mapped(input logic [glk_pkg::ADDR_W-1:0] a);
		reg_mapped = (a == glk_pkg::REG_CTRL) || (a == glk_pkg::REG_STATUS) ||
			(a == glk_pkg::REG_IRQ_STAT) || (a == glk_pkg::REG_IRQ_MASK) || (a == glk_pkg::REG_CODE);
	endfunction

	// variant selection read straight from static inputs
	assign release_var = (cfg_i.lock_pol == glk_pkg::RELEASE_ON_POWER);

	glk_code_check u_code (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.coding_i(cfg_i.coding),
		.teach_i(teach_req),
		.present_i(actuator_present_i),
		.suitable_i(actuator_suitable_i),
		.code_i(actuator_code_i),
		.valid_o(code_ok),
		.taught_o(taught),
		.teach_done_o(teach_done),
		.stored_o(stored_code)
	);

	glk_test_pulse #(
		.PERIOD_CYC(TEST_PERIOD_CYC),
		.PULSE_CYC(TEST_PULSE_CYC)
	) u_test (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.enable_i(out_st == glk_pkg::OUT_ON),
		.fb_i(channel_fb_i),
		.test_off_o(test_off),
		.fault_o(test_fault)
	);

	// lock requests per polarity variant
	always_comb begin
		manual_now = release_var && manual_release_i;
		if (release_var) begin
			// no voltage engages, voltage releases; supply loss gives neither
			engage_req = supply_ok_i && !lock_ctrl_i && !manual_now;
			// manual release wins over any lock state
			release_req = manual_now || (supply_ok_i && lock_ctrl_i);
		end else begin
			engage_req = lock_ctrl_i;
			release_req = !lock_ctrl_i;
		end
	end

	// engage only on a valid code
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			lock_st <= glk_pkg::LK_RELEASED;
		end else begin
			case (lock_st)
				glk_pkg::LK_RELEASED: begin
					if (engage_req && code_ok) begin
						lock_st <= glk_pkg::LK_ENGAGED;
					end
				end
				glk_pkg::LK_ENGAGED: begin
					// without supply the bistable lock keeps its state unless manually released
					if (release_req) begin
						lock_st <= glk_pkg::LK_RELEASED;
					end
				end
				default: begin
					lock_st <= glk_pkg::LK_RELEASED;
				end
			endcase
		end
	end

	// manual release keeps outputs off until the guard has been opened once
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			manual_flag <= 1'b0;
		end else if (manual_now) begin
			manual_flag <= 1'b1;
		end else if (!actuator_present_i) begin
			manual_flag <= 1'b0;
		end
	end

	// switch-on conditions of the configured protection variant
	always_comb begin
		cond = actuator_present_i && code_ok && control_input_a_i && control_input_b_i &&
			!manual_flag && !manual_now;
		// people protection also needs the lock engaged
		if (cfg_i.prot == glk_pkg::PROT_PEOPLE) begin
			cond = cond && (lock_st == glk_pkg::LK_ENGAGED);
		end
	end

	// condition must hold over two evaluations before switch-on
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cond_q <= 1'b0;
		end else begin
			cond_q <= cond;
		end
	end

	always_comb begin
		next_out_st = out_st;
		case (out_st)
			glk_pkg::OUT_OFF: begin
				if (cond && cond_q) begin
					next_out_st = glk_pkg::OUT_ON;
				end
			end
			glk_pkg::OUT_ON: begin
				if (test_fault) begin
					next_out_st = glk_pkg::OUT_FAULT;
				end else if (!cond) begin
					next_out_st = glk_pkg::OUT_OFF;
				end
			end
			glk_pkg::OUT_FAULT: begin
				// fault clears only by software and only with conditions gone
				if (fault_clr && !cond) begin
					next_out_st = glk_pkg::OUT_OFF;
				end
			end
			default: begin
				next_out_st = glk_pkg::OUT_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			out_st <= glk_pkg::OUT_OFF;
		end else begin
			out_st <= next_out_st;
		end
	end

	// high when on, low when off, opened, manually released, faulted, or unlocked under people protection
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			safety_output_channel_o <= 2'h0;
		end else if (next_out_st == glk_pkg::OUT_ON) begin
			// both channels driven together, test pulses one at a time
			safety_output_channel_o <= ~test_off;
		end else begin
			// manual release and every other off case drop both
			safety_output_channel_o <= 2'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			diag_o <= 1'b0;
			present_q <= 1'b0;
			lock_engaged_o <= 1'b0;
		end else begin
			diag_o <= actuator_present_i;
			present_q <= actuator_present_i;
			lock_engaged_o <= (lock_st == glk_pkg::LK_ENGAGED);
		end
	end

	// apb: pready rises in the second access cycle, so every transfer takes one wait state
	assign apb_access = psel_i && penable_i && !pready_o;
	assign apb_wr = apb_access && pwrite_i;
	assign teach_req = apb_wr && (paddr_i == glk_pkg::REG_CTRL) && pwdata_i[glk_pkg::CTRL_TEACH];
	assign fault_clr = apb_wr && (paddr_i == glk_pkg::REG_CTRL) && pwdata_i[glk_pkg::CTRL_FAULT_CLR];
	assign irq_clr = (apb_wr && (paddr_i == glk_pkg::REG_IRQ_STAT)) ? pwdata_i[glk_pkg::IRQ_W-1:0] : '0;

	always_comb begin
		status_word = '0;
		status_word[glk_pkg::ST_GUARD] = actuator_present_i;
		status_word[glk_pkg::ST_LOCK] = (lock_st == glk_pkg::LK_ENGAGED);
		status_word[glk_pkg::ST_OUT_A] = safety_output_channel_o[0];
		status_word[glk_pkg::ST_OUT_B] = safety_output_channel_o[1];
		status_word[glk_pkg::ST_CODE_OK] = code_ok;
		status_word[glk_pkg::ST_FAULT] = (out_st == glk_pkg::OUT_FAULT);
		status_word[glk_pkg::ST_TAUGHT] = taught;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= '0;
		end else begin
			pready_o <= apb_access;
			pslverr_o <= apb_access && !reg_mapped(paddr_i);
			prdata_o <= '0;
			if (apb_access && !pwrite_i) begin
				case (paddr_i)
					glk_pkg::REG_STATUS: prdata_o <= status_word;
					glk_pkg::REG_IRQ_STAT: prdata_o <= {{(glk_pkg::DATA_W-glk_pkg::IRQ_W){1'b0}}, irq_stat};
					glk_pkg::REG_IRQ_MASK: prdata_o <= {{(glk_pkg::DATA_W-glk_pkg::IRQ_W){1'b0}}, irq_mask};
					glk_pkg::REG_CODE: prdata_o <= stored_code;
					default: prdata_o <= '0;
				endcase
			end
		end
	end

	always_comb begin
		events = '0;
		events[glk_pkg::IRQ_OPEN] = present_q && !actuator_present_i;
		events[glk_pkg::IRQ_CLOSE] = !present_q && actuator_present_i;
		events[glk_pkg::IRQ_OUT_OFF] = (out_st == glk_pkg::OUT_ON) && (next_out_st != glk_pkg::OUT_ON);
		events[glk_pkg::IRQ_FAULT] = test_fault;
		events[glk_pkg::IRQ_TEACH] = teach_done;
	end

	// a new event wins over a write-one-to-clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			irq_stat <= '0;
			irq_mask <= glk_pkg::IRQ_MASK_RST;
			irq_o <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | events;
			if (apb_wr && (paddr_i == glk_pkg::REG_IRQ_MASK)) begin
				irq_mask <= pwdata_i[glk_pkg::IRQ_W-1:0];
			end
			irq_o <= |(((irq_stat & ~irq_clr) | events) & irq_mask);
		end
	end

	a_power_loss_rel: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(!release_var && !lock_ctrl_i) |=> (lock_st == glk_pkg::LK_RELEASED) ##1 !lock_engaged_o)
		else $error("lock held without voltage in power-to-lock");
	a_release_engage: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(release_var && supply_ok_i && !lock_ctrl_i && !manual_release_i && code_ok) |=>
		(lock_st == glk_pkg::LK_ENGAGED))
		else $error("power-to-release lock not engaged without voltage");
	a_supply_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(release_var && !supply_ok_i && !manual_release_i) |=> $stable(lock_st))
		else $error("bistable lock changed during supply loss");
	a_engage_code: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$rose(lock_st == glk_pkg::LK_ENGAGED) |-> $past(code_ok))
		else $error("lock engaged without a valid code");
	a_people_lock: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(cfg_i.prot == glk_pkg::PROT_PEOPLE && safety_output_channel_o != 2'h0) |->
		$past(lock_st == glk_pkg::LK_ENGAGED))
		else $error("people-protection output on while unlocked");
	a_on_inputs: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(safety_output_channel_o != 2'h0) |-> $past(actuator_present_i && control_input_a_i && control_input_b_i))
		else $error("output on without closed guard and both inputs");
	a_manual_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(release_var && manual_release_i) |=> (safety_output_channel_o == 2'h0) [*2])
		else $error("outputs on after manual release");
	a_reset_off: assert property (@(posedge clk_i)
		(!nrst_i ##1 nrst_i) |-> (safety_output_channel_o == 2'h0) ##1 (safety_output_channel_o == 2'h0))
		else $error("outputs on right after reset");
	a_fault_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(out_st == glk_pkg::OUT_FAULT) |-> (safety_output_channel_o == 2'h0))
		else $error("outputs on during fault");
	a_diag_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$fell(actuator_present_i) |=> !diag_o)
		else $error("diagnostic output on with guard open");
	a_lock_engage: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(!release_var && lock_ctrl_i && code_ok) |=> (lock_st == glk_pkg::LK_ENGAGED))
		else $error("power-to-lock lock not engaged with voltage present");
	a_rel_release: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(release_var && supply_ok_i && lock_ctrl_i) |=> (lock_st == glk_pkg::LK_RELEASED))
		else $error("power-to-release lock held with voltage applied");
	a_unlocked_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(cfg_i.prot == glk_pkg::PROT_PEOPLE && lock_st == glk_pkg::LK_RELEASED) |=>
		(safety_output_channel_o == 2'h0))
		else $error("people-protection outputs on after unlock");
	a_switch_on: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(out_st == glk_pkg::OUT_OFF && cond && cond_q) |=> (safety_output_channel_o == 2'h3))
		else $error("outputs not switched on with conditions met");
	a_fault_stop: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(out_st == glk_pkg::OUT_ON && test_fault) |=> (out_st == glk_pkg::OUT_FAULT))
		else $error("failed self-test did not stop outputs");
	a_diag_closed: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$rose(actuator_present_i) |=> diag_o)
		else $error("diagnostic output off with guard closed");
	a_manual_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
		manual_flag |=> (safety_output_channel_o == 2'h0))
		else $error("outputs on before guard reopened after manual release");
	a_cond_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(out_st == glk_pkg::OUT_ON && !cond) |=> (safety_output_channel_o == 2'h0))
		else $error("outputs on with switch-on conditions gone");
endmodule
`default_nettype wire

/* File: include/glk_pkg.sv */
// constants, types and register map of the guard-lock safety output controller
package glk_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int TEST_PULSE_US = 300;
	// divide first: the plain product would overflow a 32-bit int
	localparam int TEST_PULSE_CYC = TEST_PULSE_US * (CLK_HZ / 1_000_000);
	localparam int TEST_PERIOD_MS = 100;
	localparam int TEST_PERIOD_CYC = TEST_PERIOD_MS * (CLK_HZ / 1_000);
	localparam int CNT_W = 23;
	localparam int CODE_W = 32;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_CODE = 8'h10;
	localparam int CTRL_TEACH = 0;
	localparam int CTRL_FAULT_CLR = 1;
	localparam int ST_GUARD = 0;
	localparam int ST_LOCK = 1;
	localparam int ST_OUT_A = 2;
	localparam int ST_OUT_B = 3;
	localparam int ST_CODE_OK = 4;
	localparam int ST_FAULT = 5;
	localparam int ST_TAUGHT = 6;
	localparam int IRQ_OPEN = 0;
	localparam int IRQ_CLOSE = 1;
	localparam int IRQ_OUT_OFF = 2;
	localparam int IRQ_FAULT = 3;
	localparam int IRQ_TEACH = 4;
	localparam int IRQ_W = 5;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
	localparam logic [CODE_W-1:0] CODE_RST = 32'h00000000;

	typedef enum logic {LOCK_ON_POWER, RELEASE_ON_POWER} glk_lock_pol_e;
	typedef enum logic {PROT_PEOPLE, PROT_PROCESS} glk_prot_e;
	typedef enum logic {CODE_UNIQUE, CODE_UNIVERSAL} glk_coding_e;
	typedef struct packed {
		glk_lock_pol_e lock_pol;
		glk_prot_e prot;
		glk_coding_e coding;
	} glk_cfg_s;
	typedef enum logic {LK_RELEASED, LK_ENGAGED} glk_lock_e;
	typedef enum logic [1:0] {OUT_OFF, OUT_ON, OUT_FAULT} glk_out_e;
endpackage

/* File: logic/glk_code_check.sv */
// actuator code store and validity judgement
`timescale 1ns/10ps
`default_nettype none
module glk_code_check (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire glk_pkg::glk_coding_e coding_i,
	input wire logic teach_i,
	input wire logic present_i,
	input wire logic suitable_i,
	input wire logic [glk_pkg::CODE_W-1:0] code_i,
	output logic valid_o,
	output logic taught_o,
	output logic teach_done_o,
	output logic [glk_pkg::CODE_W-1:0] stored_o
);
	logic teach_ok;
	assign teach_ok = teach_i && present_i && suitable_i && (coding_i == glk_pkg::CODE_UNIQUE);

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			stored_o <= glk_pkg::CODE_RST;
			taught_o <= 1'b0;
			teach_done_o <= 1'b0;
		end else begin
			teach_done_o <= teach_ok;
			if (teach_ok) begin
				stored_o <= code_i;
				taught_o <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			valid_o <= 1'b0;
		end else if (coding_i == glk_pkg::CODE_UNIVERSAL) begin
			valid_o <= present_i && suitable_i;
		end else begin
			valid_o <= present_i && suitable_i && taught_o && (code_i == stored_o);
		end
	end

	a_teach_replace: assert property (@(posedge clk_i) disable iff (!nrst_i)
		teach_ok |=> (stored_o == $past(code_i)) ##1 (valid_o == $past(code_i == stored_o && present_i && suitable_i)))
		else $error("taught code not stored or judged");
	a_universal_ok: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(coding_i == glk_pkg::CODE_UNIVERSAL && present_i && suitable_i) |=> valid_o)
		else $error("suitable actuator refused in universal coding");
endmodule
`default_nettype wire

/* File: logic/glk_test_pulse.sv */
// periodic off-pulse self-test of both safety channels
`timescale 1ns/10ps
`default_nettype none
module glk_test_pulse #(
	parameter int PERIOD_CYC = glk_pkg::TEST_PERIOD_CYC,
	parameter int PULSE_CYC = glk_pkg::TEST_PULSE_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic enable_i,
	input wire logic [1:0] fb_i,
	output logic [1:0] test_off_o,
	output logic fault_o
);
	logic [glk_pkg::CNT_W-1:0] cnt;
	logic [1:0] phase;
	logic last;

	assign last = (cnt == glk_pkg::CNT_W'(PULSE_CYC - 1));

	// phase 0 waits, phase 1 tests channel a, phase 2 channel b
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !enable_i) begin
			cnt <= '0;
			phase <= 2'h0;
		end else if (phase == 2'h0) begin
			cnt <= (cnt == glk_pkg::CNT_W'(PERIOD_CYC - 1)) ? '0 : cnt + 1'b1;
			if (cnt == glk_pkg::CNT_W'(PERIOD_CYC - 1)) begin
				phase <= 2'h1;
			end
		end else begin
			cnt <= last ? '0 : cnt + 1'b1;
			if (last) begin
				phase <= (phase == 2'h1) ? 2'h2 : 2'h0;
			end
		end
	end

	// one channel off at a time
	always_comb begin
		test_off_o[0] = (phase == 2'h1);
		test_off_o[1] = (phase == 2'h2);
	end

	// channel must be voltage-free by end of pulse
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			fault_o <= 1'b0;
		end else begin
			fault_o <= enable_i && last && (phase != 2'h0) && fb_i[phase[1]];
		end
	end

	a_pulse_bound: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(phase != 2'h0) |-> (cnt < glk_pkg::CNT_W'(PULSE_CYC)))
		else $error("test pulse longer than allowed");
	a_one_channel: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!(test_off_o[0] && test_off_o[1]))
		else $error("both channels tested at once");
endmodule
`default_nettype wire

/* File: verification/glk_ctrl_partner.sv */
// model of the evaluating safety controller at the far side
`timescale 1ns/10ps
`default_nettype none
module glk_ctrl_partner #(
	parameter int PULSE_CYC = 8
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [1:0] safety_output_channel_i,
	input wire logic demand_i,
	input wire logic stuck_i,
	output logic control_input_a_o,
	output logic control_input_b_o,
	output logic [1:0] channel_fb_o,
	output logic stop_o
);
	logic [7:0] off_cnt_a;
	logic [7:0] off_cnt_b;
	logic long_off;
	assign control_input_a_o = demand_i;
	assign control_input_b_o = demand_i;
	// stuck_i models a readback shorted to supply, so a test pulse is not seen
	assign channel_fb_o = stuck_i ? 2'h3 : safety_output_channel_i;
	assign long_off = (off_cnt_a > 8'(PULSE_CYC)) || (off_cnt_b > 8'(PULSE_CYC));
	// each channel timed alone, since pulses follow back to back
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			off_cnt_a <= 8'h00;
			off_cnt_b <= 8'h00;
			stop_o <= 1'b1;
		end else begin
			off_cnt_a <= safety_output_channel_i[0] ? 8'h00 :
				((off_cnt_a == 8'hFF) ? off_cnt_a : off_cnt_a + 8'h01);
			off_cnt_b <= safety_output_channel_i[1] ? 8'h00 :
				((off_cnt_b == 8'hFF) ? off_cnt_b : off_cnt_b + 8'h01);
			stop_o <= (safety_output_channel_i != 2'h3) && (stop_o || long_off);
		end
	end
endmodule
`default_nettype wire

/* File: verification/glk_guard_lock_ctrl_test.sv */
// self-checking bench of the guard-lock controller
`timescale 1ns/10ps
`default_nettype none
module glk_guard_lock_ctrl_test;
	localparam glk_pkg::glk_cfg_s PPL = '{glk_pkg::LOCK_ON_POWER, glk_pkg::PROT_PEOPLE, glk_pkg::CODE_UNIQUE};
	localparam glk_pkg::glk_cfg_s REL = '{glk_pkg::RELEASE_ON_POWER, glk_pkg::PROT_PROCESS, glk_pkg::CODE_UNIVERSAL};
	localparam glk_pkg::glk_cfg_s PRC = '{glk_pkg::LOCK_ON_POWER, glk_pkg::PROT_PROCESS, glk_pkg::CODE_UNIVERSAL};
	logic clk_i;
	logic nrst_i;
	glk_pkg::glk_cfg_s cfg;
	logic lock_ctrl;
	logic supply_ok;
	logic manual;
	logic present;
	logic suitable;
	logic [31:0] code;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] chan;
	logic [1:0] fb;
	logic lock;
	logic diag;
	logic irq;
	logic in_a;
	logic in_b;
	logic stop;
	logic demand;
	logic stuck;
	logic [31:0] rd;
	logic err;
	int errors;
	int checks;
	int n;

	glk_guard_lock_ctrl #(
		.TEST_PERIOD_CYC(64),
		.TEST_PULSE_CYC(8)
	) u_dut (
		.clk_i,
		.nrst_i,
		.cfg_i(cfg),
		.lock_ctrl_i(lock_ctrl),
		.supply_ok_i(supply_ok),
		.manual_release_i(manual),
		.actuator_present_i(present),
		.actuator_suitable_i(suitable),
		.actuator_code_i(code),
		.control_input_a_i(in_a),
		.control_input_b_i(in_b),
		.channel_fb_i(fb),
		.psel_i(psel),
		.penable_i(penable),
		.pwrite_i(pwrite),
		.paddr_i(paddr),
		.pwdata_i(pwdata),
		.prdata_o(prdata),
		.pready_o(pready),
		.pslverr_o(pslverr),
		.safety_output_channel_o(chan),
		.lock_engaged_o(lock),
		.diag_o(diag),
		.irq_o(irq)
	);

	glk_ctrl_partner #(
		.PULSE_CYC(8)
	) u_ctrl (
		.clk_i,
		.nrst_i,
		.safety_output_channel_i(chan),
		.demand_i(demand),
		.stuck_i(stuck),
		.control_input_a_o(in_a),
		.control_input_b_o(in_b),
		.channel_fb_o(fb),
		.stop_o(stop)
	);

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic final_report();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, seen);
			errors++;
		end
	endtask

	task automatic limit(input int i, input int lim);
		if (i == lim) begin
			errors++;
			final_report();
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	// request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (pready === 1'b1) begin
				break;
			end
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		limit(i, 20);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		check(name, rd, exp);
	endtask

	task automatic wait_chan(input logic [1:0] v);
		int i;
		for (i = 0; i < 200; i++) begin
			@(posedge clk_i);
			if (chan === v) begin
				break;
			end
		end
		limit(i, 200);
	endtask

	// counts the cycles a test pulse pattern stands
	task automatic pulse(input logic [1:0] v);
		if (chan !== v) begin
			wait_chan(v);
		end
		n = 0;
		while (chan === v && n < 50) begin
			n++;
			@(posedge clk_i);
		end
	endtask

	// config changes only under reset, as it is static in use
	task automatic restart(input glk_pkg::glk_cfg_s c);
		@(posedge clk_i);
		nrst_i <= 1'b0;
		cfg <= c;
		lock_ctrl <= 1'b0;
		supply_ok <= 1'b1;
		manual <= 1'b0;
		present <= 1'b0;
		suitable <= 1'b1;
		demand <= 1'b1;
		stuck <= 1'b0;
		tick(10);
		nrst_i <= 1'b1;
	endtask

	initial begin
		nrst_i = 1'b0;
		cfg = PPL;
		lock_ctrl = 1'b0;
		supply_ok = 1'b1;
		manual = 1'b0;
		present = 1'b0;
		suitable = 1'b0;
		code = 32'hA5A50001;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		demand = 1'b0;
		stuck = 1'b0;
		errors = 0;
		checks = 0;
		restart(PPL);
		tick(2);
		check("chan", 32'(chan), 32'h0);
		rd_chk("mask", glk_pkg::REG_IRQ_MASK, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		check("unmapped", {rd[30:0], err}, 32'h1);
		present <= 1'b1;
		lock_ctrl <= 1'b1;
		tick(10);
		check("lock", 32'(lock), 32'h0);
		check("chan", 32'(chan), 32'h0);
		check("diag", 32'(diag), 32'h1);
		apb(1'b1, glk_pkg::REG_CTRL, 32'h1);
		tick(10);
		check("lock", 32'(lock), 32'h1);
		check("chan", 32'(chan), 32'h3);
		rd_chk("code", glk_pkg::REG_CODE, 32'hA5A50001);
		rd_chk("status", glk_pkg::REG_STATUS, 32'h5F);
		manual <= 1'b1;
		tick(4);
		check("lock", 32'(lock), 32'h1);
		manual <= 1'b0;
		lock_ctrl <= 1'b0;
		tick(14);
		check("lock", 32'(lock), 32'h0);
		check("chan", 32'(chan), 32'h0);
		check("stop", 32'(stop), 32'h1);
		present <= 1'b0;
		tick(4);
		check("diag", 32'(diag), 32'h0);
		code <= 32'h5A5A0002;
		present <= 1'b1;
		apb(1'b1, glk_pkg::REG_CTRL, 32'h1);
		tick(4);
		present <= 1'b0;
		tick(4);
		code <= 32'hA5A50001;
		present <= 1'b1;
		lock_ctrl <= 1'b1;
		tick(10);
		check("lock", 32'(lock), 32'h0);
		rd_chk("irq stat", glk_pkg::REG_IRQ_STAT, 32'h17);
		check("irq", 32'(irq), 32'h0);
		apb(1'b1, glk_pkg::REG_IRQ_MASK, 32'h1F);
		tick(2);
		check("irq", 32'(irq), 32'h1);
		apb(1'b1, glk_pkg::REG_IRQ_STAT, 32'h1F);
		tick(2);
		check("irq", 32'(irq), 32'h0);
		restart(REL);
		present <= 1'b1;
		tick(10);
		check("lock", 32'(lock), 32'h1);
		check("chan", 32'(chan), 32'h3);
		lock_ctrl <= 1'b1;
		tick(4);
		check("lock", 32'(lock), 32'h0);
		check("chan", 32'(chan), 32'h3);
		lock_ctrl <= 1'b0;
		tick(4);
		supply_ok <= 1'b0;
		lock_ctrl <= 1'b1;
		tick(4);
		check("lock", 32'(lock), 32'h1);
		supply_ok <= 1'b1;
		lock_ctrl <= 1'b0;
		manual <= 1'b1;
		tick(12);
		check("lock", 32'(lock), 32'h0);
		check("chan", 32'(chan), 32'h0);
		check("stop", 32'(stop), 32'h1);
		restart(PRC);
		present <= 1'b1;
		wait_chan(2'h3);
		pulse(2'h2);
		check("pulse a", 32'(n), 32'h8);
		pulse(2'h1);
		check("pulse b", 32'(n), 32'h8);
		check("stop", 32'(stop), 32'h0);
		stuck <= 1'b1;
		wait_chan(2'h0);
		rd_chk("status", glk_pkg::REG_STATUS, 32'h31);
		rd_chk("irq stat", glk_pkg::REG_IRQ_STAT, 32'h0E);
		demand <= 1'b0;
		apb(1'b1, glk_pkg::REG_CTRL, 32'h2);
		rd_chk("status", glk_pkg::REG_STATUS, 32'h11);
		demand <= 1'b1;
		wait_chan(2'h3);
		check("chan", 32'(chan), 32'h3);
		final_report();
	end
endmodule
`default_nettype wire
